//--- logic/prd_route_diag.sv
// routing, polarity, high-side dead-time and feedback coherency diagnostics for ls7/8 and hs1-7
// Function
// RULE1 - routing field picks flag or sequencer only
// RULE2 - selected flag ORed with sequencer command
// RULE3 - invert flips sequencer part, not flag
// RULE4 - error lookup uses actual post-invert command
// RULE5 - low-side override ignores global driver enable
// RULE6 - high-side override writable only hs5, hs7
// RULE7 - drain table indexed by command and feedback
// RULE8 - source table indexed the same way
// RULE9 - selected table bit one raises error
// RULE10 - blank checks window plus four after change
// RULE11 - filter mode resets or decrements counter
// RULE12 - filter needs length plus one samples
// RULE13 - freewheel rises dead time after fall; code raises it dead time plus one after request fall
// RULE14 - high-side rise delayed dead time plus one
// RULE15 - ls7/8 share filter, window, table scheme
// RULE16 - flags come from flag source selection
// RULE17 - routing field resets to all ones
// RULE18 - error detected within one clock cycle
// RULE19 - option selects requested or actual drive
`timescale 1ns/1ps
`include "prd_defines.svh"

module prd_route_diag #(
  parameter int NUM_LS = 2,
  parameter int NUM_HS = 7
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire prd_pkg::prd_addr_t reg_addr,
  input wire prd_pkg::prd_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output prd_pkg::prd_word_t reg_rdata,
  output logic reg_rvalid,
  // sequencer commands and flags
  input wire logic [NUM_LS+NUM_HS-1:0] seq_cmd,
  input wire logic [15:0] flag_vec,
  // global driver gating
  input wire logic drv_en,
  input wire logic drv_fault,
  // feedback comparators
  input wire logic [NUM_LS-1:0] lowside_drain_feedback,
  input wire logic [NUM_HS-1:0] highside_drain_feedback,
  input wire logic [NUM_HS-1:0] highside_source_feedback,
  // pre-driver commands
  output logic [NUM_LS-1:0] lowside_cmd,
  output logic [NUM_HS-1:0] highside_cmd,
  output logic [NUM_HS-1:0] freewheel_cmd,
  // diagnostics toward microcores
  output logic [NUM_LS+NUM_HS-1:0] diag_err_drain,
  output logic [NUM_HS-1:0] diag_err_source,
  output logic diag_err_any
);

  localparam int NCH = NUM_LS + NUM_HS;

  localparam prd_pkg::prd_addr_t CFG1_OFS [9] = '{
    `PRD_LS7_CFG1_OFS, `PRD_LS8_CFG1_OFS, `PRD_HS1_CFG1_OFS,
    `PRD_HS2_CFG1_OFS, `PRD_HS3_CFG1_OFS, `PRD_HS4_CFG1_OFS,
    `PRD_HS5_CFG1_OFS, `PRD_HS6_CFG1_OFS, `PRD_HS7_CFG1_OFS
  };
  localparam prd_pkg::prd_addr_t CFG2_OFS [9] = '{
    `PRD_LS7_CFG2_OFS, `PRD_LS8_CFG2_OFS, `PRD_HS1_CFG2_OFS,
    `PRD_HS2_CFG2_OFS, `PRD_HS3_CFG2_OFS, `PRD_HS4_CFG2_OFS,
    `PRD_HS5_CFG2_OFS, `PRD_HS6_CFG2_OFS, `PRD_HS7_CFG2_OFS
  };
  localparam prd_pkg::prd_addr_t ROUTE_OFS [9] = '{
    `PRD_LS7_ROUTE_OFS, `PRD_LS8_ROUTE_OFS, `PRD_HS1_ROUTE_OFS,
    `PRD_HS2_ROUTE_OFS, `PRD_HS3_ROUTE_OFS, `PRD_HS4_ROUTE_OFS,
    `PRD_HS5_ROUTE_OFS, `PRD_HS6_ROUTE_OFS, `PRD_HS7_ROUTE_OFS
  };

  // saturating six-bit increment
  function automatic prd_pkg::prd_cnt_t inc_sat(input prd_pkg::prd_cnt_t v);
    prd_pkg::prd_cnt_t r;
    r = (v == 6'h3F) ? v : v + 6'h01;
    return r;
  endfunction

  // one step of a feedback filter: {filtered, counter}
  function automatic logic [6:0] filt_step(
    input logic smp,
    input logic flt,
    input prd_pkg::prd_cnt_t cnt,
    input prd_pkg::prd_cnt_t len,
    input logic mode
  );
    logic [6:0] r;
    r = {flt, cnt};
    if (smp != flt) begin
      if (cnt == len) begin
        r = {smp, 6'h00};
      end else begin
        r = {flt, inc_sat(cnt)};
      end
    end else if (mode) begin
      r = {flt, (cnt == 6'h00) ? 6'h00 : cnt - 6'h01};
    end else begin
      r = {flt, 6'h00};
    end
    return r;
  endfunction

  // configuration storage
  prd_pkg::prd_word_t cfg1_r [NCH];
  prd_pkg::prd_word_t cfg2_r [NCH];
  prd_pkg::prd_word_t route_r [NCH];
  prd_pkg::prd_word_t diag_opt_r;
  prd_pkg::prd_word_t reg_rdata_r;
  logic reg_rvalid_r;
  logic diag_err_any_r;

  // write decode
  logic [NCH-1:0] hit_cfg1;
  logic [NCH-1:0] hit_cfg2;
  logic [NCH-1:0] hit_route;
  prd_pkg::prd_word_t cfg2_mask [NCH];
  prd_pkg::prd_word_t route_mask [NCH];
  wire logic hit_opt = reg_wr && (reg_addr == `PRD_DIAG_OPT_OFS);

  // per-channel results
  logic [NCH-1:0] cmd_out;
  logic [NCH-1:0] coast_out;
  logic [NCH-1:0] err_drain;
  logic [NCH-1:0] err_src;
  logic [NCH-1:0] err_drain_nxt;
  logic [NCH-1:0] err_src_nxt;

  wire logic [NCH-1:0] drain_fb = {highside_drain_feedback, lowside_drain_feedback};
  wire logic [NCH-1:0] src_fb = {highside_source_feedback, {NUM_LS{1'b0}}};
  wire logic diag_use_actual = diag_opt_r[`PRD_DIAG_OPT_BIT];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : dec
      localparam prd_pkg::prd_kind_t KIND =
        (g >= NUM_LS) ? prd_pkg::PRD_KIND_HS : prd_pkg::PRD_KIND_LS;
      localparam bit OVR_OK = (g == NUM_LS + `PRD_HS_OVR_A) || (g == NUM_LS + `PRD_HS_OVR_B);
      assign hit_cfg1[g] = reg_wr && (reg_addr == CFG1_OFS[g]);
      assign hit_cfg2[g] = reg_wr && (reg_addr == CFG2_OFS[g]);
      assign hit_route[g] = reg_wr && (reg_addr == ROUTE_OFS[g]);
      assign cfg2_mask[g] = (KIND == prd_pkg::PRD_KIND_HS) ?
        `PRD_CFG2_HS_WMASK : `PRD_CFG2_LS_WMASK;
      // high-side override bit only exists where it is writable (see RULE6)
      assign route_mask[g] = (KIND == prd_pkg::PRD_KIND_LS) ? `PRD_ROUTE_LS_WMASK :
        (OVR_OK ? (`PRD_ROUTE_HS_WMASK | `PRD_ROUTE_OVR_WMASK) : `PRD_ROUTE_HS_WMASK);
    end
  endgenerate

  // register writes
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      for (int i = 0; i < NCH; i++) begin
        cfg1_r[i] <= `PRD_CFG_RST;
        cfg2_r[i] <= `PRD_CFG_RST;
        route_r[i] <= `PRD_ROUTE_RST; // see RULE17
      end
      diag_opt_r <= `PRD_DIAG_OPT_RST;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (hit_cfg1[i]) begin
          cfg1_r[i] <= reg_wdata & `PRD_CFG1_WMASK;
        end
        if (hit_cfg2[i]) begin
          cfg2_r[i] <= reg_wdata & cfg2_mask[i];
        end
        if (hit_route[i]) begin
          route_r[i] <= reg_wdata & route_mask[i];
        end
      end
      if (hit_opt) begin
        diag_opt_r <= reg_wdata & `PRD_DIAG_OPT_WMASK;
      end
    end
  end

  // read mux, later entries win on a shared offset
  prd_pkg::prd_word_t rd_word;
  always_comb begin
    rd_word = 16'h0000;
    for (int i = 0; i < NCH; i++) begin
      if (reg_addr == CFG1_OFS[i]) begin
        rd_word = cfg1_r[i];
      end
      if (reg_addr == CFG2_OFS[i]) begin
        rd_word = cfg2_r[i];
      end
      if (reg_addr == ROUTE_OFS[i]) begin
        rd_word = route_r[i];
      end
    end
    if (reg_addr == `PRD_DIAG_OPT_OFS) begin
      rd_word = diag_opt_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata_r <= 16'h0000;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rdata_r <= reg_rd ? rd_word : reg_rdata_r;
      reg_rvalid_r <= reg_rd;
    end
  end

  // per-channel datapath
  generate
    for (g = 0; g < NCH; g++) begin : chan
      localparam bit IS_HS = (g >= NUM_LS);

      logic req_d_r;
      prd_pkg::prd_cnt_t tmr_r;
      logic on_r;
      logic act_r;
      logic coast_r;
      logic dcmd_d_r;
      prd_pkg::prd_blank_t blank_r;
      logic dflt_r;
      prd_pkg::prd_cnt_t dcnt_r;
      logic sflt_r;
      prd_pkg::prd_cnt_t scnt_r;

      // routing and polarity
      wire logic [4:0] route = route_r[g][`PRD_ROUTE_MSB:`PRD_ROUTE_LSB];
      wire logic flag_sel = route < `PRD_ROUTE_SEQ_ONLY; // see RULE1
      wire logic flag_bit = flag_sel ? flag_vec[route[3:0]] : 1'b0; // see RULE16
      wire logic seq_pol = seq_cmd[g] ^ route_r[g][`PRD_INV_BIT]; // see RULE3
      wire logic req = seq_pol | flag_bit; // see RULE2

      // dead-time timing on high sides
      wire logic req_chg = req != req_d_r;
      wire prd_pkg::prd_cnt_t elapsed = req_chg ? 6'h00 : inc_sat(tmr_r);
      wire prd_pkg::prd_cnt_t dead = IS_HS ?
        {1'b0, route_r[g][`PRD_DEAD_MSB:`PRD_DEAD_LSB]} : 6'h00;
      wire logic dead_done = elapsed >= dead;
      wire logic on_nxt = req && (!IS_HS || dead_done); // see RULE14
      wire logic coast_nxt = IS_HS && !req && dead_done; // see RULE13

      // driver enable gating
      wire logic ovr = route_r[g][`PRD_OVR_BIT];
      wire logic act_nxt = on_nxt && (ovr || drv_en) && !drv_fault; // see RULE5

      // command seen by the coherency check
      wire logic diag_cmd = diag_use_actual ? act_r : on_r; // see RULE4 RULE19
      wire logic dcmd_chg = diag_cmd != dcmd_d_r;
      wire logic [6:0] win = cfg1_r[g][`PRD_WIN_MSB:`PRD_WIN_LSB];
      wire prd_pkg::prd_blank_t blank_nxt = dcmd_chg ? ({1'b0, win} + `PRD_BLANK_EXTRA) :
        ((blank_r != 8'h00) ? blank_r - 8'h01 : 8'h00); // see RULE10 RULE15
      wire logic chk_en = !dcmd_chg && (blank_r == 8'h00);

      // feedback filters
      wire prd_pkg::prd_cnt_t flen = cfg1_r[g][`PRD_FILT_LEN_MSB:`PRD_FILT_LEN_LSB];
      wire logic fmode = cfg1_r[g][`PRD_FILT_MODE_BIT];
      wire logic [6:0] dfilt = filt_step(drain_fb[g], dflt_r, dcnt_r, flen, fmode); // see RULE11 RULE12
      wire logic [6:0] sfilt = filt_step(src_fb[g], sflt_r, scnt_r, flen, fmode); // see RULE11 RULE12

      // table lookup by {command, feedback}
      wire logic [3:0] tab_drain = cfg2_r[g][`PRD_TAB_DRAIN_MSB:`PRD_TAB_DRAIN_LSB];
      wire logic [3:0] tab_src = cfg2_r[g][`PRD_TAB_SRC_MSB:`PRD_TAB_SRC_LSB];
      wire logic [1:0] idx_drain = {diag_cmd, dflt_r}; // see RULE7
      wire logic [1:0] idx_src = {diag_cmd, sflt_r}; // see RULE8
      assign err_drain_nxt[g] = chk_en && tab_drain[idx_drain]; // see RULE9
      assign err_src_nxt[g] = IS_HS && chk_en && tab_src[idx_src]; // see RULE9

      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          req_d_r <= 1'b0;
          tmr_r <= 6'h00;
          on_r <= 1'b0;
          act_r <= 1'b0;
          coast_r <= 1'b0;
          dcmd_d_r <= 1'b0;
          blank_r <= 8'h00;
          {dflt_r, dcnt_r} <= 7'h00;
          {sflt_r, scnt_r} <= 7'h00;
        end else begin
          req_d_r <= req;
          tmr_r <= elapsed;
          on_r <= on_nxt;
          act_r <= act_nxt;
          coast_r <= coast_nxt;
          dcmd_d_r <= diag_cmd;
          blank_r <= blank_nxt;
          {dflt_r, dcnt_r} <= dfilt;
          {sflt_r, scnt_r} <= sfilt;
        end
      end

      assign cmd_out[g] = act_r;
      assign coast_out[g] = coast_r;
    end
  endgenerate

  // error flags, one cycle from the offending sample
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      err_drain <= '0;
      err_src <= '0;
      diag_err_any_r <= 1'b0;
    end else begin
      err_drain <= err_drain_nxt; // see RULE18
      err_src <= err_src_nxt;
      diag_err_any_r <= |{err_drain_nxt, err_src_nxt}; // see RULE18
    end
  end

  // outputs
  assign reg_rdata = reg_rdata_r;
  assign reg_rvalid = reg_rvalid_r;
  assign lowside_cmd = cmd_out[NUM_LS-1:0];
  assign highside_cmd = cmd_out[NCH-1:NUM_LS];
  assign freewheel_cmd = coast_out[NCH-1:NUM_LS];
  assign diag_err_drain = err_drain;
  assign diag_err_source = err_src[NCH-1:NUM_LS];
  assign diag_err_any = diag_err_any_r;

endmodule

//--- logic/prd_defines.svh
// register offsets, field positions, masks and reset values
`ifndef PRD_DEFINES_SVH
`define PRD_DEFINES_SVH

// register word offsets
`define PRD_LS7_CFG1_OFS 9'h1D2
`define PRD_LS7_CFG2_OFS 9'h1D3
`define PRD_LS7_ROUTE_OFS 9'h1D4
`define PRD_LS8_CFG1_OFS 9'h1D5
`define PRD_LS8_CFG2_OFS 9'h1D6
`define PRD_LS8_ROUTE_OFS 9'h1D7
`define PRD_HS1_CFG1_OFS 9'h1D8
`define PRD_HS1_CFG2_OFS 9'h1D9
`define PRD_HS1_ROUTE_OFS 9'h1DA
`define PRD_HS2_CFG1_OFS 9'h1DB
`define PRD_HS2_CFG2_OFS 9'h1DC
`define PRD_HS2_ROUTE_OFS 9'h1DD
`define PRD_HS3_CFG1_OFS 9'h1DE
`define PRD_HS3_CFG2_OFS 9'h1DF
`define PRD_HS3_ROUTE_OFS 9'h1E0
`define PRD_HS4_CFG1_OFS 9'h1E0
`define PRD_HS4_CFG2_OFS 9'h1E2
`define PRD_HS4_ROUTE_OFS 9'h1E3
`define PRD_HS5_CFG1_OFS 9'h1E4
`define PRD_HS5_CFG2_OFS 9'h1E5
`define PRD_HS5_ROUTE_OFS 9'h1E6
`define PRD_HS6_CFG1_OFS 9'h1E7
`define PRD_HS6_CFG2_OFS 9'h1E8
`define PRD_HS6_ROUTE_OFS 9'h1E9
`define PRD_HS7_CFG1_OFS 9'h1EA
`define PRD_HS7_CFG2_OFS 9'h1EB
`define PRD_HS7_ROUTE_OFS 9'h1EC
`define PRD_DIAG_OPT_OFS 9'h1FF

// filter and window register fields
`define PRD_FILT_MODE_BIT 13
`define PRD_FILT_LEN_MSB 12
`define PRD_FILT_LEN_LSB 7
`define PRD_WIN_MSB 6
`define PRD_WIN_LSB 0
// error table register fields
`define PRD_TAB_DRAIN_MSB 3
`define PRD_TAB_DRAIN_LSB 0
`define PRD_TAB_SRC_MSB 7
`define PRD_TAB_SRC_LSB 4
// routing and diagnostic option register fields
`define PRD_OVR_BIT 15
`define PRD_DEAD_MSB 10
`define PRD_DEAD_LSB 6
`define PRD_ROUTE_MSB 5
`define PRD_ROUTE_LSB 1
`define PRD_INV_BIT 0
`define PRD_DIAG_OPT_BIT 0

// write masks
`define PRD_CFG1_WMASK 16'h3FFF
`define PRD_CFG2_LS_WMASK 16'h000F
`define PRD_CFG2_HS_WMASK 16'h00FF
`define PRD_ROUTE_LS_WMASK 16'h803F
`define PRD_ROUTE_HS_WMASK 16'h07FF
`define PRD_ROUTE_OVR_WMASK 16'h8000
`define PRD_DIAG_OPT_WMASK 16'h0001

// reset values
`define PRD_CFG_RST 16'h0000
`define PRD_ROUTE_RST 16'h003E
`define PRD_DIAG_OPT_RST 16'h0001

// timing and routing constants
`define PRD_ROUTE_SEQ_ONLY 5'h10
`define PRD_BLANK_EXTRA 8'h04
`define PRD_HS_OVR_A 4
`define PRD_HS_OVR_B 6

`endif

//--- logic/prd_pkg.sv
// shared types of the pre-driver routing and diagnostics block
package prd_pkg;
  typedef logic [15:0] prd_word_t;
  typedef logic [8:0] prd_addr_t;
  typedef logic [5:0] prd_cnt_t;
  typedef logic [7:0] prd_blank_t;
  typedef enum logic {
    PRD_KIND_LS = 1'b0,
    PRD_KIND_HS = 1'b1
  } prd_kind_t;
endpackage

//--- sim/prd_route_diag_chk.sv
// port checker for the routing and diagnostics block
`timescale 1ns/1ps

module prd_route_diag_chk #(
  parameter int NUM_LS = 2,
  parameter int NUM_HS = 7
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic reg_rd,
  input wire prd_pkg::prd_word_t reg_rdata,
  input wire logic reg_rvalid,
  // gating and commands
  input wire logic drv_fault,
  input wire logic [NUM_LS-1:0] lowside_cmd,
  input wire logic [NUM_HS-1:0] highside_cmd,
  input wire logic [NUM_HS-1:0] freewheel_cmd,
  // diagnostics
  input wire logic [NUM_LS+NUM_HS-1:0] diag_err_drain,
  input wire logic [NUM_HS-1:0] diag_err_source,
  input wire logic diag_err_any
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence ls_quiet;
    !diag_err_drain[0] [*5];
  endsequence
  rvalid_resp_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  err_any_a: assert property (diag_err_any == |{diag_err_drain, diag_err_source})
    else $error("summary error flag wrong");
  fault_gate_a: assert property ($past(drv_fault) |-> lowside_cmd == '0)
    else $error("low-side on during fault");
  coast_excl_a: assert property ((highside_cmd & freewheel_cmd) == '0)
    else $error("high-side and freewheel overlap");
  blank_ls_a: assert property ($changed(lowside_cmd[0]) |=> ls_quiet)
    else $error("error raised inside blanking");
  reset_zero_a: assert property (disable iff (1'b0) !resetn |=> lowside_cmd == '0
      && highside_cmd == '0 && !diag_err_any && !reg_rvalid)
    else $error("outputs not cleared by reset");
endmodule

bind prd_route_diag prd_route_diag_chk #(.NUM_LS(NUM_LS), .NUM_HS(NUM_HS)) chk (.*);

//--- sim/prd_fb_model.sv
// external fets and their feedback comparators
`timescale 1ns/1ps

module prd_fb_model #(
  parameter int LAG = 2
) (
  // clock
  input wire logic ref_clk,
  // commands
  input wire logic [1:0] lowside_cmd,
  input wire logic [6:0] highside_cmd,
  // inverts the ls7 drain comparator
  input wire logic glitch,
  // comparators
  output logic [1:0] lowside_drain_feedback,
  output logic [6:0] highside_drain_feedback,
  output logic [6:0] highside_source_feedback
);
  logic [8:0] pipe [LAG];
  always @(posedge ref_clk) begin
    pipe[0] <= {highside_cmd, lowside_cmd};
    for (int i = 1; i < LAG; i++) pipe[i] <= pipe[i-1];
  end
  // an on fet pulls its drain low and lifts its source
  assign lowside_drain_feedback = ~pipe[LAG-1][1:0] ^ {1'b0, glitch};
  assign highside_drain_feedback = ~pipe[LAG-1][8:2];
  assign highside_source_feedback = pipe[LAG-1][8:2];
endmodule

//--- sim/test_prd_route_diag.sv
// self-checking bench for the routing and diagnostics block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end

module test_prd_route_diag;
  logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  logic drv_en = 1, drv_fault = 0, glitch = 0, seen, diag_err_any, reg_rvalid;
  prd_pkg::prd_addr_t reg_addr = '0;
  prd_pkg::prd_word_t reg_wdata = '0, reg_rdata, d, e, q[$];
  logic [8:0] seq_cmd = '0, diag_err_drain;
  logic [15:0] flag_vec = '0;
  logic [1:0] lowside_cmd, lowside_drain_feedback;
  logic [6:0] highside_cmd, freewheel_cmd, diag_err_source;
  logic [6:0] highside_drain_feedback, highside_source_feedback;
  int errors = 0, checks_done = 0, seed = 32'h0000_339c, n, w;
  prd_pkg::prd_addr_t ra[7] = '{9'h1d4, 9'h1da, 9'h1e6, 9'h1d3, 9'h1d9, 9'h1d2, 9'h1d0};
  prd_pkg::prd_word_t rm[7] = '{16'h803f, 16'h07ff, 16'h87ff, 16'h000f, 16'h00ff,
    16'h3fff, 16'h0000};
  prd_pkg::prd_word_t rv[7] = '{16'h003e, 16'h003e, 16'h003e, 16'h0000, 16'h0000,
    16'h0000, 16'h0000};

  prd_route_diag dut (.*);
  prd_fb_model #(.LAG(2)) fb (.*);

  initial forever #5 ref_clk = ~ref_clk;

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic wr(input prd_pkg::prd_addr_t a, input prd_pkg::prd_word_t v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1;
    cyc(1);
    reg_wr = 0;
    cyc(1);
  endtask
  task automatic rd(input prd_pkg::prd_addr_t a, input prd_pkg::prd_word_t v);
    q.push_back(v);
    reg_addr = a;
    reg_rd = 1;
    cyc(1);
    reg_rd = 0;
    cyc(1);
  endtask
  task automatic pulse_fb(input int k);
    glitch = 1;
    cyc(k);
    glitch = 0;
  endtask
  task automatic test_done;
    if (errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // read answers against the oldest note
  always @(negedge ref_clk) if (reg_rvalid === 1'b1) begin
    e = q.pop_front();
    `CHK("reg_rdata", e, reg_rdata)
  end

  initial begin
    #100000;
    errors++;
    test_done();
  end

  initial begin
    cyc(8);
    resetn = 1;
    rd(9'h1ff, 16'h0001);
    foreach (ra[i]) rd(ra[i], rv[i]);
    foreach (ra[i]) begin
      d = 16'($random(seed));
      wr(ra[i], d);
      rd(ra[i], d & rm[i]);
    end
    resetn = 0;
    cyc(2);
    resetn = 1;
    foreach (ra[i]) rd(ra[i], rv[i]);
    // flag routing
    for (int r = 0; r < 18; r++) begin
      flag_vec = 16'($random(seed));
      seq_cmd[0] = 1'($random(seed));
      seq_cmd[1] = 1'($random(seed));
      w = r > 16 ? 31 : r;
      wr(9'h1d4, 16'(w << 1));
      cyc(1);
      `CHK("ls8 route", seq_cmd[1], lowside_cmd[1])
      `CHK("route", seq_cmd[0] | (w < 16 && flag_vec[w[3:0]]), lowside_cmd[0])
    end
    for (int v = 0; v < 8; v++) begin
      flag_vec[0] = v[2];
      seq_cmd[0] = v[1];
      wr(9'h1d4, 16'(v[0]));
      cyc(1);
      `CHK("invert", (v[1] ^ v[0]) | v[2], lowside_cmd[0])
    end
    // enable override
    flag_vec = '0;
    seq_cmd[0] = 1;
    drv_en = 0;
    for (int v = 0; v < 4; v++) begin
      drv_fault = v[1];
      wr(9'h1d4, v[0] ? 16'h803e : 16'h003e);
      cyc(1);
      `CHK("override", v[0] & !v[1], lowside_cmd[0])
    end
    drv_en = 1;
    drv_fault = 0;
    seq_cmd[0] = 0;
    // dead time
    w = $random(seed) & 31;
    wr(9'h1da, 16'(w << 6) | 16'h003e);
    seq_cmd[2] = 1;
    for (n = 0; highside_cmd[0] !== 1'b1 && n < 40; n++) cyc(1);
    `CHK("rise delay", w + 1, n)
    cyc(2);
    seq_cmd[2] = 0;
    for (n = 0; freewheel_cmd[0] !== 1'b1 && n < 40; n++) cyc(1);
    `CHK("freewheel delay", w + 1, n)
    // error tables on the driven state
    for (int c = 0; c < 2; c++) begin
      wr(9'h1d4, 16'(c) | 16'h003e);
      wr(9'h1da, 16'(c) | 16'h003e);
      for (int k = 0; k < 4; k++) begin
        wr(9'h1d3, 16'(1 << k));
        wr(9'h1d9, 16'(17 << k));
        cyc(8);
        `CHK("ls drain", k == c + 1, diag_err_drain[0])
        `CHK("hs drain", k == c + 1, diag_err_drain[2])
        `CHK("hs source", k == 3 * c, diag_err_source[0])
      end
    end
    // blanking window
    wr(9'h1d4, 16'h003e);
    wr(9'h1da, 16'h003e);
    w = $random(seed) & 127;
    wr(9'h1d2, 16'(w));
    wr(9'h1d3, 16'h0004);
    cyc(8);
    seq_cmd[0] = 1;
    for (n = 0; diag_err_drain[0] !== 1'b1 && n < 200; n++) cyc(1);
    `CHK("blank window", w + 7, n)
    // feedback filter
    wr(9'h1d3, 16'h0008);
    for (int p = 0; p < 3; p++) begin
      wr(9'h1d2, p == 1 ? 16'h2180 : 16'h0180);
      cyc(8);
      pulse_fb(p == 2 ? 4 : 3);
      if (p < 2) begin
        cyc(1);
        pulse_fb(2);
      end
      seen = 0;
      repeat (10) begin
        cyc(1);
        seen = seen | diag_err_drain[0];
      end
      `CHK("filter", p > 0, seen)
    end
    // requested or actual drive
    drv_fault = 1;
    cyc(8);
    for (int o = 0; o < 2; o++) begin
      wr(9'h1ff, 16'(o));
      cyc(12);
      `CHK("diag option", o == 0, diag_err_drain[0])
    end
    drv_fault = 0;
    cyc(10);
    test_done();
  end
endmodule
